// File: cmch_cpu_end.sv
`timescale 1ns/1ps
`default_nettype none
module cmch_cpu_end
    import cmch_pkg::*;
(
    input  wire logic                        sys_clk_in,
    input  wire logic                        srst_in,
    cmch_chan_if.cpu                         chan,
    input  wire logic [N_CH-1:0]             job_start_in,
    input  wire logic [N_CH-1:0][ADDR_W-1:0] job_addr_in,
    input  wire logic [N_CH-1:0][LEN_W-1:0]  job_len_in,
    input  wire logic [N_CH-1:0]             job_cancel_in,
    input  wire logic                        fetch_space_in,
    input  wire logic                        prefetch_full_in,
    input  wire logic                        store_in,
    input  wire logic [DATA_W-1:0]           store_data_in,
    output logic      [N_CH-1:0]             job_busy_out,
    output logic      [N_CH-1:0]             word_valid_out,
    output logic      [N_CH-1:0][DATA_W-1:0] word_out,
    output logic                             store_take_out
);
    logic [N_CH-1:0]             rdy;
    logic [N_CH-1:0]             ack;
    logic [N_CH-1:0]             want;
    logic [N_CH-1:0]             go;
    logic [N_CH-1:0]             inreq;
    logic [N_CH-1:0]             brq;
    logic [N_CH-1:0]             first;
    logic [N_CH-1:0]             act;
    logic [N_CH-1:0][ADDR_W-1:0] nxt_addr;
    logic [N_CH-1:0]             val_q, val_d;
    logic [N_CH-1:0][DATA_W-1:0] wrd_q, wrd_d;
    logic                        wr_q, wr_d;
    logic                        sp_q, sp_d;
    logic [DATA_W-1:0]           wd_q, wd_d;

    // An error ends a word like a ready; the word is still marked valid in word_valid_out
    assign rdy = {~chan.data_ready_n | ~chan.data_error_n, ~chan.instr_ready_n | ~chan.instr_error_n};
    assign ack = {~chan.data_burst_ack_n, ~chan.instr_burst_ack_n};
    // Instruction fetch wins the shared address bus; an access on it is never cut short
    assign go[CH_I] = want[CH_I] & ~inreq[CH_D];
    assign go[CH_D] = want[CH_D] & ~inreq[CH_I] & ~go[CH_I];

    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        cmch_cst_e        st_q, st_d;
        logic             job_q, job_d;
        logic             first_q, first_d;
        logic             lead_q, lead_d;
        logic [ADDR_W-1:0] a_q, a_d;
        logic [LEN_W-1:0] left_q, left_d;
        logic [LEN_W-1:0] acc_q, acc_d;
        logic             hold;

        assign hold = (c == CH_I) & prefetch_full_in;
        assign want[c] = job_q & (left_q != LEN_RST) & (st_q == c_idle) & ~hold;
        assign inreq[c] = st_q == c_req;
        assign first[c] = first_q;
        assign act[c] = st_q != c_idle;
        assign job_busy_out[c] = job_q;
        assign nxt_addr[c] = a_q;
        assign brq[c] = ((st_q == c_req) & (acc_q > 8'h01)) | ((st_q == c_burst) & (acc_q != LEN_RST) & ~hold);

        always_comb begin
            st_d = st_q;
            job_d = job_q;
            first_d = 1'b0;
            lead_d = lead_q;
            a_d = a_q;
            left_d = left_q;
            acc_d = acc_q;
            if (rdy[c] & act[c]) begin
                a_d = a_q + ADDR_STEP;
                left_d = left_q - 1'b1;
                acc_d = acc_q - 1'b1;
            end
            case (st_q)
                c_idle: begin
                    if (job_start_in[c] & ~job_q) begin
                        job_d = 1'b1;
                        lead_d = 1'b1;
                        a_d = job_addr_in[c];
                        left_d = job_len_in[c];
                    end else if (job_q & (left_q == LEN_RST)) begin
                        job_d = 1'b0;
                    end else if (go[c]) begin
                        st_d = c_req;
                        first_d = 1'b1;
                        lead_d = 1'b0;
                        if (c != CH_D) begin
                            acc_d = left_q;
                        end else if (lead_q | (left_q == 8'h01)) begin
                            acc_d = 8'h01;
                        end else begin
                            acc_d = left_q - 1'b1;
                        end
                    end
                end
                c_req: begin
                    if (first_q & job_cancel_in[c]) begin
                        st_d = c_idle;
                        job_d = 1'b0;
                    end else if (ack[c] & (acc_d != LEN_RST)) begin
                        st_d = c_burst;
                    end else if (rdy[c] | ack[c]) begin
                        st_d = c_idle;
                    end
                end
                c_burst: begin
                    if ((acc_d == LEN_RST) | (~ack[c] & ~rdy[c])) begin
                        st_d = c_idle;
                    end
                end
                default: st_d = c_idle;
            endcase
        end

        always_ff @(posedge sys_clk_in) begin
            if (srst_in) begin
                st_q <= c_idle;
                job_q <= 1'b0;
                first_q <= 1'b0;
                lead_q <= 1'b0;
                a_q <= ADDR_RST;
                left_q <= LEN_RST;
                acc_q <= LEN_RST;
            end else begin
                st_q <= st_d;
                job_q <= job_d;
                first_q <= first_d;
                lead_q <= lead_d;
                a_q <= a_d;
                left_q <= left_d;
                acc_q <= acc_d;
            end
        end
    end

    assign chan.instr_request_n = ~inreq[CH_I];
    assign chan.data_request_n = ~inreq[CH_D];
    assign chan.instr_burst_request_n = ~brq[CH_I];
    assign chan.data_burst_request_n = ~brq[CH_D];
    assign chan.addr = inreq[CH_I] ? nxt_addr[CH_I] : nxt_addr[CH_D];
    assign chan.instr_space_select = sp_q;
    assign chan.data_write = wr_q;
    assign chan.data_wdata = wd_q;
    assign chan.cycle_invalid_n = ~|(inreq & first & job_cancel_in);
    assign store_take_out = val_d[CH_D] & wr_q;
    assign word_valid_out = val_q;
    assign word_out = wrd_q;

    always_comb begin
        val_d = rdy & act;
        wrd_d = wrd_q;
        wr_d = wr_q;
        sp_d = sp_q;
        wd_d = wd_q;
        if (val_d[CH_I]) begin
            wrd_d[CH_I] = chan.instr_word;
        end
        if (val_d[CH_D]) begin
            wrd_d[CH_D] = chan.data_rdata;
        end
        if (job_start_in[CH_I] & ~job_busy_out[CH_I]) begin
            sp_d = fetch_space_in;
        end
        if ((job_start_in[CH_D] & ~job_busy_out[CH_D]) | store_take_out) begin
            wd_d = store_data_in;
        end
        if (job_start_in[CH_D] & ~job_busy_out[CH_D]) begin
            wr_d = store_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            val_q <= '0;
            wrd_q <= '0;
            wr_q <= 1'b0;
            sp_q <= 1'b0;
            wd_q <= '0;
        end else begin
            val_q <= val_d;
            wrd_q <= wrd_d;
            wr_q <= wr_d;
            sp_q <= sp_d;
            wd_q <= wd_d;
        end
    end
endmodule : cmch_cpu_end
`default_nettype wire

// File: cmch_pkg.sv
`default_nettype none
package cmch_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int LEN_W = 8;
    localparam int N_CH = 2;
    localparam int CH_I = 0;
    localparam int CH_D = 1;
    localparam int WORD_LSB = 2;
    // Burst address counter width
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_LAST = 8'hff;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    // Initial access length; two is the least, since burst request is registered
    localparam int FIRST_CYC = 2;
    localparam logic [7:0] FIRST_WAIT = 8'(FIRST_CYC - 2);
    localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0004;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
    localparam logic [LEN_W-1:0] LEN_RST = 8'h00;

    typedef enum logic [1:0] {m_idle, m_first, m_burst, m_final} cmch_mst_e;
    typedef enum logic [1:0] {c_idle, c_req, c_burst} cmch_cst_e;
endpackage : cmch_pkg
`default_nettype wire

// File: cmch_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cmch_chan_if;
    import cmch_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic              instr_space_select;
    logic              cycle_invalid_n;
    logic              instr_request_n;
    logic              instr_burst_request_n;
    logic              data_request_n;
    logic              data_burst_request_n;
    logic              data_write;
    logic [DATA_W-1:0] data_wdata;
    logic              instr_ready_n;
    logic              instr_error_n;
    logic              instr_burst_ack_n;
    logic              data_ready_n;
    logic              data_error_n;
    logic              data_burst_ack_n;
    logic              pipeline_enable_n;
    logic [DATA_W-1:0] instr_word;
    logic [DATA_W-1:0] data_rdata;

    modport cpu (
        output addr, instr_space_select, cycle_invalid_n, instr_request_n, instr_burst_request_n,
        output data_request_n, data_burst_request_n, data_write, data_wdata,
        input  instr_ready_n, instr_error_n, instr_burst_ack_n, data_ready_n, data_error_n,
        input  data_burst_ack_n, pipeline_enable_n, instr_word, data_rdata
    );
    modport mem (
        input  addr, instr_space_select, cycle_invalid_n, instr_request_n, instr_burst_request_n,
        input  data_request_n, data_burst_request_n, data_write, data_wdata,
        output instr_ready_n, instr_error_n, instr_burst_ack_n, data_ready_n, data_error_n,
        output data_burst_ack_n, pipeline_enable_n, instr_word, data_rdata
    );
endinterface : cmch_chan_if
`default_nettype wire

// File: cmch_mem_end.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Processor request marks valid instruction address
// - Memory returns word with ready asserted
// - Space select decoded as address bit
// - Bus invalid cancels the starting access
// - Burst request registered, used second cycle
// - Latch address, 8-bit counter makes rest
// - Acknowledge answers burst request
// - Processor drops request after acknowledge seen
// - Suspend drops request; ready stops after
// - Resume if acknowledge held, else new
// - Acknowledge combinational, off on new request
// - Preempt owes one final word first
// - Data channel uses same handshake
// - Multiple transfer: simple, burst, simple
// - Two-word multiple is two simples
// - Fetch may come between data parts
// - Pipeline enable only from selected interface
// - Pipeline enable may be tied
// - Responses valid every cycle end
// - One interface drives responses each cycle
// - Responses merged by gating, not tristate
// - Levels at rising edge, synchronous tracking
module cmch_mem_end
    import cmch_pkg::*;
#(
    parameter int                IDX_W        = 6,
    parameter int                REGION_LSB   = WORD_LSB + IDX_W,
    parameter logic [ADDR_W-1:0] REGION_BASE  = 32'h0000_0000,
    parameter logic              REGION_SPACE = 1'b0,
    parameter logic              PIPE_OK      = 1'b1
)(
    input  wire logic                        sys_clk_in,
    input  wire logic                        srst_in,
    cmch_chan_if.mem                         chan,
    input  wire logic [N_CH-1:0]             preempt_in,
    input  wire logic [N_CH-1:0]             chain_ready_n_in,
    input  wire logic [N_CH-1:0]             chain_error_n_in,
    input  wire logic [N_CH-1:0]             chain_ack_n_in,
    input  wire logic                        chain_pen_n_in,
    input  wire logic [N_CH-1:0][DATA_W-1:0] chain_word_in,
    output logic      [N_CH-1:0]             busy_out
);
    localparam int DEPTH = 2 ** IDX_W;
    localparam logic [ADDR_W-1:0] OOB_MASK = ADDR_W'((64'd1 << (REGION_LSB - WORD_LSB - IDX_W)) - 64'd1);

    logic [N_CH-1:0]             req_n;
    logic [N_CH-1:0]             brq_n;
    logic [N_CH-1:0]             rdy;
    logic [N_CH-1:0]             err;
    logic [N_CH-1:0]             ack;
    logic [N_CH-1:0]             start;
    logic [N_CH-1:0]             own;
    logic [N_CH-1:0]             wr;
    logic [N_CH-1:0][IDX_W-1:0]  idx;
    logic [N_CH-1:0][DATA_W-1:0] word;
    logic [DATA_W-1:0]           mem_q [DEPTH];
    logic [DATA_W-1:0]           mem_d [DEPTH];
    logic                        in_region;
    logic                        oob;

    assign req_n = {chan.data_request_n, chan.instr_request_n};
    assign brq_n = {chan.data_burst_request_n, chan.instr_burst_request_n};
    assign in_region = ((chan.addr ^ REGION_BASE) >> REGION_LSB) == '0;
    // An access that starts above the implemented depth but inside the region answers with error
    assign oob = ((chan.addr >> (WORD_LSB + IDX_W)) & OOB_MASK) != '0;

    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        cmch_mst_e        st_q, st_d;
        logic             brq_q;
        logic [7:0]       cnt_q, cnt_d;
        logic [CNT_W-1:0] ctr_q, ctr_d;
        logic             wr_q, wr_d;
        logic             oob_q, oob_d;
        logic [DATA_W-1:0] w_q, w_d;
        logic             req;
        logic             brq;
        logic             sel;
        logic             pre;
        logic             word_first;

        assign req = ~req_n[c];
        assign brq = ~brq_n[c];
        assign sel = in_region & ((c == CH_D) | (chan.instr_space_select == REGION_SPACE));
        // no new access while a final word is owed
        assign start[c] = req & chan.cycle_invalid_n & sel & (st_q != m_first) & (st_q != m_final);
        // Counter end forces preemption so a burst never wraps inside the page
        assign pre = preempt_in[c] | (ctr_q == CNT_LAST);
        assign word_first = (st_q == m_first) & (cnt_q == FIRST_WAIT);
        assign ack[c] = ((st_q == m_first) & brq_q & ~pre & ~oob_q) | ((st_q == m_burst) & ~req & ~pre);
        assign rdy[c] = (word_first & ~oob_q) | ((st_q == m_burst) & ~req & brq) | (st_q == m_final);
        assign err[c] = word_first & oob_q;
        assign own[c] = st_q != m_idle;
        assign wr[c] = wr_q;
        assign idx[c] = ctr_q[IDX_W-1:0];
        assign word[c] = w_q;

        always_comb begin
            st_d = st_q;
            cnt_d = cnt_q;
            ctr_d = ctr_q;
            wr_d = wr_q;
            oob_d = oob_q;
            if (rdy[c]) begin
                ctr_d = ctr_q + 1'b1;
            end
            case (st_q)
                m_idle: begin
                    if (start[c]) begin
                        st_d = m_first;
                    end
                end
                m_first: begin
                    if (cnt_q != FIRST_WAIT) begin
                        cnt_d = cnt_q + 1'b1;
                    end else if (brq_q & ~pre & ~oob_q) begin
                        st_d = m_burst;
                    end else begin
                        st_d = m_idle;
                    end
                end
                m_burst: begin
                    if (start[c]) begin
                        st_d = m_first;
                    end else if (req) begin
                        st_d = m_idle;
                    end else if (pre) begin
                        st_d = brq ? m_idle : m_final;
                    end
                end
                m_final: st_d = m_idle;
                default: st_d = m_idle;
            endcase
            if (start[c]) begin
                cnt_d = 8'h00;
                ctr_d = chan.addr[WORD_LSB +: CNT_W];
                wr_d = (c == CH_D) & chan.data_write;
                oob_d = oob;
            end
            w_d = mem_q[ctr_d[IDX_W-1:0]];
        end

        always_ff @(posedge sys_clk_in) begin
            if (srst_in) begin
                st_q <= m_idle;
                brq_q <= 1'b0;
                cnt_q <= 8'h00;
                ctr_q <= CNT_RST;
                wr_q <= 1'b0;
                oob_q <= 1'b0;
                w_q <= '0;
            end else begin
                st_q <= st_d;
                brq_q <= brq;
                cnt_q <= cnt_d;
                ctr_q <= ctr_d;
                wr_q <= wr_d;
                oob_q <= oob_d;
                w_q <= w_d;
            end
        end
    end

    // Stores land on the edge that ends the word; a fetch of the same word then reads old data
    always_comb begin
        mem_d = mem_q;
        if (rdy[CH_D] & wr[CH_D]) begin
            mem_d[idx[CH_D]] = chan.data_wdata;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            mem_q <= '{default: '0};
        end else begin
            mem_q <= mem_d;
        end
    end

    assign chan.instr_ready_n = ~rdy[CH_I] & chain_ready_n_in[CH_I];
    assign chan.data_ready_n = ~rdy[CH_D] & chain_ready_n_in[CH_D];
    assign chan.instr_error_n = ~err[CH_I] & chain_error_n_in[CH_I];
    assign chan.data_error_n = ~err[CH_D] & chain_error_n_in[CH_D];
    assign chan.instr_burst_ack_n = ~ack[CH_I] & chain_ack_n_in[CH_I];
    assign chan.data_burst_ack_n = ~ack[CH_D] & chain_ack_n_in[CH_D];
    assign chan.pipeline_enable_n = ~(PIPE_OK & |start) & chain_pen_n_in;
    assign chan.instr_word = (own[CH_I] ? word[CH_I] : '0) | chain_word_in[CH_I];
    assign chan.data_rdata = (own[CH_D] ? word[CH_D] : '0) | chain_word_in[CH_D];
    assign busy_out = own;
endmodule : cmch_mem_end
`default_nettype wire

// File: cmch_chan_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cmch_chan_sva (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic cycle_invalid_n,
    input wire logic instr_request_n,
    input wire logic instr_burst_request_n,
    input wire logic instr_ready_n,
    input wire logic instr_burst_ack_n,
    input wire logic data_request_n,
    input wire logic data_ready_n,
    input wire logic data_burst_ack_n,
    input wire logic pipeline_enable_n
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (srst_in);

    // A valid new access starts where the request first goes low
    sequence s_inew;
        $fell(instr_request_n) ##0 cycle_invalid_n;
    endsequence
    sequence s_dnew;
        $fell(data_request_n) ##0 cycle_invalid_n;
    endsequence

    a_iack_new_off: assert property (s_inew |-> instr_burst_ack_n)
        else $error("fetch ack low on new access");
    a_dack_new_off: assert property (s_dnew |-> data_burst_ack_n)
        else $error("data ack low on new access");
    a_instr_request_n_release: assert property (!instr_request_n && !instr_burst_ack_n |=> instr_request_n)
        else $error("fetch request kept after ack");
    a_data_request_n_release: assert property (!data_request_n && !data_burst_ack_n |=> data_request_n)
        else $error("data request kept after ack");
    a_inv_ignored: assert property ($fell(instr_request_n) && !cycle_invalid_n |=> instr_ready_n)
        else $error("cancelled fetch answered");
    a_fetch_answer: assert property (s_inew |=> !instr_ready_n)
        else $error("fetch word not given");
    a_data_answer: assert property (s_dnew |=> !data_ready_n)
        else $error("data word not given");
    a_suspend_quiet: assert property (
        instr_request_n && instr_burst_request_n && !instr_burst_ack_n |-> instr_ready_n)
        else $error("ready during suspension");
    a_burst_flow: assert property (
        instr_request_n && !instr_burst_request_n && !instr_burst_ack_n |-> !instr_ready_n)
        else $error("no word while bursting");
    a_owed_word: assert property (
        $rose(instr_burst_ack_n) && instr_request_n && instr_burst_request_n |-> ##[0:2] !instr_ready_n)
        else $error("owed final word missing");
    a_pen_start: assert property (!pipeline_enable_n |-> !instr_request_n || !data_request_n)
        else $error("pipeline enable without access");
    a_instr_request_n_hold: assert property (
        !instr_request_n && instr_ready_n && instr_burst_ack_n && cycle_invalid_n |=> !instr_request_n)
        else $error("fetch request dropped early");
endmodule : cmch_chan_sva
`default_nettype wire

// File: test_cmch.sv
`timescale 1ns/1ps
`default_nettype none
module test_cmch
    import cmch_pkg::*;
;
    logic                        sys_clk = 1'b0;
    logic                        srst    = 1'b1;
    logic [N_CH-1:0]             start   = '0;
    logic [N_CH-1:0]             cancel  = '0;
    logic [N_CH-1:0]             preempt = '0;
    logic [N_CH-1:0][ADDR_W-1:0] jaddr   = '0;
    logic [N_CH-1:0][LEN_W-1:0]  jlen    = '0;
    logic                        space   = 1'b0;
    logic                        full    = 1'b0;
    logic                        store   = 1'b0;
    logic [DATA_W-1:0]           st_base = '0;
    logic [7:0]                  st_idx  = '0;
    logic [DATA_W-1:0]           st_data;
    logic [N_CH-1:0]             busy;
    logic [N_CH-1:0]             wval;
    logic [N_CH-1:0][DATA_W-1:0] wout;
    logic                        take;
    logic [N_CH-1:0]             mbusy;
    logic [DATA_W-1:0]           got [N_CH][$];
    int                          n_fail      = 0;
    int                          comparisons = 0;

    always #12.5 sys_clk = ~sys_clk;
    // A taken store word must be replaced by the next one within the same cycle
    assign st_data = st_base + {22'h0, st_idx + {7'h0, take}, 2'b00};

    always @(posedge sys_clk) begin
        if (take === 1'b1) begin
            st_idx <= st_idx + 8'h01;
        end
        for (int c = 0; c < N_CH; c++) begin
            if (wval[c] === 1'b1) begin
                got[c].push_back(wout[c]);
            end
        end
    end

    cmch_chan_if cmch_chan_if_i ();
    cmch_cpu_end cmch_cpu_end_i (.sys_clk_in(sys_clk), .srst_in(srst), .chan(cmch_chan_if_i),
        .job_start_in(start), .job_addr_in(jaddr), .job_len_in(jlen), .job_cancel_in(cancel),
        .fetch_space_in(space), .prefetch_full_in(full), .store_in(store), .store_data_in(st_data),
        .job_busy_out(busy), .word_valid_out(wval), .word_out(wout), .store_take_out(take));
    cmch_mem_end cmch_mem_end_i (.sys_clk_in(sys_clk), .srst_in(srst), .chan(cmch_chan_if_i),
        .preempt_in(preempt), .chain_ready_n_in('1), .chain_error_n_in('1), .chain_ack_n_in('1),
        .chain_pen_n_in(1'b1), .chain_word_in('0), .busy_out(mbusy));
    cmch_chan_sva cmch_chan_sva_i (.sys_clk_in(sys_clk), .srst_in(srst),
        .cycle_invalid_n(cmch_chan_if_i.cycle_invalid_n), .instr_request_n(cmch_chan_if_i.instr_request_n),
        .instr_burst_request_n(cmch_chan_if_i.instr_burst_request_n),
        .instr_ready_n(cmch_chan_if_i.instr_ready_n), .instr_burst_ack_n(cmch_chan_if_i.instr_burst_ack_n),
        .data_request_n(cmch_chan_if_i.data_request_n), .data_ready_n(cmch_chan_if_i.data_ready_n),
        .data_burst_ack_n(cmch_chan_if_i.data_burst_ack_n),
        .pipeline_enable_n(cmch_chan_if_i.pipeline_enable_n));

    function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
        return 32'h5a00_0000 + a;
    endfunction : pat

    task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] act);
        comparisons++;
        if (act !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, act);
        end
    endtask : chk

    task automatic job(input int ch, input logic [ADDR_W-1:0] a, input logic [LEN_W-1:0] n, input logic st);
        @(posedge sys_clk);
        jaddr[ch] <= a;
        jlen[ch] <= n;
        store <= st;
        st_base <= pat(a) - {22'h0, st_idx, 2'b00};
        got[ch].delete();
        @(posedge sys_clk);
        start[ch] <= 1'b1;
        @(posedge sys_clk);
        start[ch] <= 1'b0;
    endtask : job

    task automatic finish_job(input string name, input int ch, input logic [ADDR_W-1:0] a, input int n,
                              input bit vals);
        int i;
        i = 0;
        do begin
            @(posedge sys_clk);
            #1;
            i++;
        end while (busy[ch] !== 1'b0 && i < 2000);
        chk("busy", 32'h0, {31'h0, busy[ch]});
        chk("word count", 32'(n), 32'(got[ch].size()));
        for (int k = 0; vals && k < got[ch].size(); k++) begin
            chk("word", pat(a + 32'(4 * k)), got[ch][k]);
        end
        $display("test %s done", name);
    endtask : finish_job

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        job(CH_I, 32'h0000_0010, 8'h01, 1'b0);
        finish_job("simple fetch", CH_I, 32'h0, 1, 1'b0);
        job(CH_I, 32'h0000_0020, 8'h05, 1'b0);
        finish_job("burst fetch", CH_I, 32'h0, 5, 1'b0);
        job(CH_I, 32'h0000_0040, 8'h08, 1'b0);
        repeat (2) @(posedge sys_clk);
        full <= 1'b1;
        // Short stall with acknowledge held, then resume
        repeat (2) @(posedge sys_clk);
        full <= 1'b0;
        repeat (2) @(posedge sys_clk);
        full <= 1'b1;
        @(posedge sys_clk);
        preempt[CH_I] <= 1'b1;
        @(posedge sys_clk);
        preempt[CH_I] <= 1'b0;
        repeat (3) @(posedge sys_clk);
        full <= 1'b0;
        finish_job("suspend preempt", CH_I, 32'h0, 8, 1'b0);
        job(CH_D, 32'h0000_0080, 8'h06, 1'b1);
        finish_job("store multiple", CH_D, 32'h0, 6, 1'b0);
        job(CH_D, 32'h0000_0080, 8'h06, 1'b0);
        finish_job("load multiple", CH_D, 32'h0000_0080, 6, 1'b1);
        job(CH_D, 32'h0000_00c0, 8'h02, 1'b1);
        finish_job("store pair", CH_D, 32'h0, 2, 1'b0);
        job(CH_D, 32'h0000_00c0, 8'h02, 1'b0);
        finish_job("load pair", CH_D, 32'h0000_00c0, 2, 1'b1);
        job(CH_D, 32'h0000_0080, 8'h06, 1'b0);
        // Lands on the second word of the burst
        repeat (6) @(posedge sys_clk);
        preempt[CH_D] <= 1'b1;
        @(posedge sys_clk);
        preempt[CH_D] <= 1'b0;
        finish_job("data preempt", CH_D, 32'h0000_0080, 6, 1'b1);
        job(CH_D, 32'h0000_0080, 8'h06, 1'b0);
        job(CH_I, 32'h0000_0084, 8'h04, 1'b0);
        finish_job("mixed data", CH_D, 32'h0000_0080, 6, 1'b1);
        finish_job("mixed fetch", CH_I, 32'h0000_0084, 4, 1'b1);
        cancel[CH_I] <= 1'b1;
        job(CH_I, 32'h0000_0050, 8'h03, 1'b0);
        finish_job("cancel", CH_I, 32'h0, 0, 1'b0);
        end_of_test();
    end
endmodule : test_cmch
`default_nettype wire
